// ==== src/srtd_top.sv ====
// Strap decode, input termination control and receiver-detect polling.
// Assumes strap and sense pins are asynchronous; software uses a classic Wishbone master.
`timescale 1ns/1ns

// Contract
// R1 - Each control strap resolves to low, resistor-to-ground, floating or high.
// R2 - With the reset/power-down strap high, low power and every group high impedance.
// R3 - Path-mode low gives manual mux mode with 50 ohms on all three groups.
// R4 - Path-mode high gives manual fanout mode with 50 ohms on all three groups.
// R5 - The system must not strap path-mode to resistor-to-ground during normal operation.
// R6 - Path-mode floating with side select low or resistor polls B side, A stays high Z.
// R7 - Path-mode floating with side select floating or high polls A side, B stays high Z.
// R8 - Automatic detection probes every 12 msec and stops once a receiver is found.
// R9 - A polled group stays high impedance until its receiver is found.
// R10 - A successful detection switches that group to 50 ohms and holds it.
// R11 - Swing and de-emphasis of each side follow its two-pin de-emphasis strap pair.
// R12 - The poll timer and detection restart on a mode change or power-down assertion.
module srtd_top
  import srtd_pkg::*;
#(
  parameter int POLL_PERIOD = POLL_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  // Wishbone slave.
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output      logic [31:0]                wb_dat_o,
  output      logic                       wb_ack_o,
  // Straps, as pad comparator thermometer codes.
  input  wire logic                       resetStrap,
  input  wire logic [2:0]                 pathModeStrap,
  input  wire logic [2:0]                 sideChoiceStrapA,
  input  wire logic [2:0]                 sideChoiceStrapB,
  input  wire logic [1:0][1:0][2:0]       deemphasisStrapPair,
  // Far-end receiver detection per group.
  input  wire logic [srtd_pkg::NUM_GRP-1:0] rxSense,
  output      logic [srtd_pkg::NUM_GRP-1:0] rxProbe,
  // Termination and driver settings.
  output      logic [srtd_pkg::NUM_GRP-1:0] termOn,
  output      logic                       lowPower,
  output      logic [1:0][3:0]            outputSwing,
  output      logic [1:0][4:0]            deemphasisLevel
);
  import srtd_pkg::*;

  localparam int SYNC_W = 1 + 3 + 3 + 3 + 12 + NUM_GRP;
  localparam int CNT_W  = $clog2(POLL_PERIOD);
  // The power-down bit resets high so the decode opens in low power, never in mux mode.
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W - 1){1'b0}}};

  initial begin
    if (POLL_PERIOD < 2) $error("POLL_PERIOD must be at least 2");
  end

  // Every strap and sense pin passes two flops before any decode looks at it.
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= SYNC_RST; // R2
      syncB_q <= SYNC_RST;
    end else if (ce) begin
      syncA_q <= {resetStrap, pathModeStrap, sideChoiceStrapA, sideChoiceStrapB,
                  deemphasisStrapPair, rxSense};
      syncB_q <= syncA_q;
    end
  end

  logic                      rstStrapS;
  logic [2:0]                pathS;
  logic [2:0]                selAS;
  logic [2:0]                selBS;
  logic [1:0][1:0][2:0]      demS;
  logic [NUM_GRP-1:0]        senseS;

  assign {rstStrapS, pathS, selAS, selBS, demS, senseS} = syncB_q;

  // Side choice b is strapped to the same level as side choice a; only a is decoded.
  srtd_level_t pathLvl;
  srtd_level_t selLvl;
  srtd_mode_t  mode_d;

  assign pathLvl = levelOf(pathS); // R1
  assign selLvl  = levelOf(selAS); // R1

  always_comb begin
    if (rstStrapS) begin
      mode_d = MODE_LOWPWR; // R2
    end else begin
      case (pathLvl)
        LVL_LOW:   mode_d = MODE_MUX; // R3
        LVL_HIGH:  mode_d = MODE_FANOUT; // R4
        LVL_FLOAT: mode_d = (selLvl == LVL_LOW || selLvl == LVL_RES) ?
                            MODE_POLL_B : MODE_POLL_A; // R6 R7
        default:   mode_d = MODE_RSVD; // R5
      endcase
    end
  end

  srtd_mode_t mode_q;
  logic       ctrlPause_q;
  logic       restart_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_LOWPWR;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  // Poll timebase; restarting it keeps each group's first probe a full interval out.
  logic             timerClear;
  logic [CNT_W-1:0] pollCnt_q;
  logic             tick_q;

  assign timerClear = (mode_d != mode_q) || rstStrapS || restart_q; // R12

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pollCnt_q <= '0;
      tick_q    <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (timerClear) begin
        pollCnt_q <= '0; // R12
      end else if (pollCnt_q == CNT_W'(POLL_PERIOD - 1)) begin
        pollCnt_q <= '0;
        tick_q    <= !ctrlPause_q; // R8
      end else begin
        pollCnt_q <= pollCnt_q + CNT_W'(1);
      end
    end
  end

  // Detection engines, one per input group.
  logic [NUM_GRP-1:0] autoGrp;
  logic [NUM_GRP-1:0] found;
  logic [NUM_GRP-1:0] probe;

  assign autoGrp[GRP_A] = (mode_q == MODE_POLL_A); // R7
  assign autoGrp[GRP_B] = (mode_q == MODE_POLL_B); // R6
  assign autoGrp[GRP_D] = (mode_q == MODE_POLL_A) || (mode_q == MODE_POLL_B);

  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : gen_grp
      srtd_det_if det ();
      assign det.ce     = ce;
      assign det.clear  = timerClear; // R12
      assign det.enable = autoGrp[g];
      assign det.tick   = tick_q;
      assign det.sense  = senseS[g];
      assign found[g]   = det.found;
      assign probe[g]   = det.probe;
      srtd_rx_detect #(.WAIT(PROBE_WAIT_CYCLES)) u_det (
        .clk  (clk),
        .rstn (rstn),
        .det  (det.engine)
      );
    end
  endgenerate

  // Termination per group; the reserved path-mode level is held high impedance.
  logic [NUM_GRP-1:0] term_d;

  always_comb begin
    case (mode_q)
      MODE_MUX, MODE_FANOUT:   term_d = '1; // R3 R4
      MODE_POLL_A, MODE_POLL_B: term_d = autoGrp & found; // R9 R10
      default:                 term_d = '0; // R2
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      termOn   <= '0;
      lowPower <= 1'b1;
      rxProbe  <= '0;
    end else if (ce) begin
      termOn   <= term_d;
      lowPower <= (mode_q == MODE_LOWPWR); // R2
      rxProbe  <= probe;
    end
  end

  // Driver settings, one lookup per side.
  genvar s;
  generate
    for (s = 0; s < NUM_SIDE; s++) begin : gen_side
      logic [8:0] setting;
      assign setting = deemphLookup({levelOf(demS[s][1]), levelOf(demS[s][0])}); // R11
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          outputSwing[s]     <= 4'h6;
          deemphasisLevel[s] <= 5'h00;
        end else if (ce) begin
          outputSwing[s]     <= setting[8:5]; // R11
          deemphasisLevel[s] <= setting[4:0];
        end
      end
    end
  endgenerate

  // Wishbone slave: ack one cycle after the request, for one cycle; writes land with ack.
  logic        wbReq;
  logic        wbWrite;
  logic [31:0] status;

  assign wbReq   = wb_cyc_i && wb_stb_i;
  assign wbWrite = wbReq && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_comb begin
    status = 32'h0000_0000;
    status[ST_MODE_LSB +: 3]   = mode_q;
    status[ST_TERM_LSB +: 3]   = termOn;
    status[ST_FOUND_LSB +: 3]  = found;
    status[ST_LOWPWR_BIT]      = lowPower;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wbReq && !wb_ack_o;
      if (wbReq && !wb_ack_o) begin
        case (wb_adr_i)
          ADDR_STATUS: wb_dat_o <= status;
          ADDR_CTRL:   wb_dat_o <= {31'h0000_0000, ctrlPause_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlPause_q <= CTRL_PAUSE_RST;
      restart_q   <= 1'b0;
    end else if (ce) begin
      restart_q <= 1'b0;
      if (wbWrite && wb_adr_i == ADDR_CTRL) begin
        ctrlPause_q <= wb_dat_i[CTL_PAUSE_BIT];
        restart_q   <= wb_dat_i[CTL_RESTART_BIT];
      end
    end
  end

endmodule

// ==== src/srtd_pkg.sv ====
// Shared constants and types for the strap termination and receiver-detect block.
// Assumes a 50 MHz system clock and strap levels already quantised by pad comparators.
package srtd_pkg;

  // Timebase.
  localparam int CLK_HZ             = 50_000_000;
  localparam int POLL_MS            = 12;
  localparam int POLL_CYCLES        = (CLK_HZ / 1000) * POLL_MS;
  localparam int PROBE_WAIT_CYCLES  = 8;

  // Group indices: A-side inputs, B-side inputs, downstream inputs.
  localparam int GRP_A              = 0;
  localparam int GRP_B              = 1;
  localparam int GRP_D              = 2;
  localparam int NUM_GRP            = 3;
  localparam int NUM_SIDE           = 2;

  // Register map, byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;

  // Status fields.
  localparam int ST_MODE_LSB        = 0;
  localparam int ST_TERM_LSB        = 4;
  localparam int ST_FOUND_LSB       = 8;
  localparam int ST_LOWPWR_BIT      = 12;

  // Control fields and reset value.
  localparam int CTL_PAUSE_BIT      = 0;
  localparam int CTL_RESTART_BIT    = 1;
  localparam logic CTRL_PAUSE_RST   = 1'b0;

  typedef enum logic [1:0] {LVL_LOW, LVL_RES, LVL_FLOAT, LVL_HIGH} srtd_level_t;

  typedef enum logic [2:0] {
    MODE_LOWPWR, MODE_MUX, MODE_RSVD, MODE_POLL_B, MODE_POLL_A, MODE_FANOUT
  } srtd_mode_t;

  // Three comparator outputs at 0.2, 0.5 and 0.8 of supply form a thermometer code.
  function automatic srtd_level_t levelOf(input logic [2:0] therm);
    if (therm[2]) return LVL_HIGH;
    if (therm[1]) return LVL_FLOAT;
    if (therm[0]) return LVL_RES;
    return LVL_LOW;
  endfunction

  // Swing in 100 mV units, de-emphasis in half-dB units, indexed by {pin1, pin0} levels.
  function automatic logic [8:0] deemphLookup(input logic [3:0] idx);
    case (idx)
      4'h0:    return {4'h6, 5'h00};
      4'h1:    return {4'h8, 5'h00};
      4'h2:    return {4'h8, 5'h07};
      4'h3:    return {4'h9, 5'h00};
      4'h4:    return {4'h9, 5'h07};
      4'h5:    return {4'h9, 5'h0c};
      4'h6:    return {4'ha, 5'h00};
      4'h7:    return {4'ha, 5'h07};
      4'h8:    return {4'ha, 5'h0c};
      4'h9:    return {4'hb, 5'h00};
      4'ha:    return {4'hb, 5'h07};
      4'hb:    return {4'hb, 5'h0c};
      4'hc:    return {4'hc, 5'h00};
      4'hd:    return {4'hc, 5'h07};
      4'he:    return {4'hc, 5'h0c};
      default: return {4'hc, 5'h12};
    endcase
  endfunction

endpackage

// ==== src/srtd_det_if.sv ====
// Link between the top and one receiver-detect engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface srtd_det_if;
  logic ce;
  logic clear;
  logic enable;
  logic tick;
  logic sense;
  logic probe;
  logic found;

  modport top    (output ce, output clear, output enable, output tick, output sense,
                  input probe, input found);
  modport engine (input ce, input clear, input enable, input tick, input sense,
                  output probe, output found);
endinterface

// ==== src/srtd_rx_detect.sv ====
// One far-end receiver-detect engine for one input group.
// Assumes tick arrives once per poll interval and sense is already synchronised.
`timescale 1ns/1ns
module srtd_rx_detect
  import srtd_pkg::*;
#(
  parameter int WAIT = PROBE_WAIT_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control link.
  srtd_det_if.engine det
);

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_FOUND} srtd_det_state_t;

  srtd_det_state_t state_q;
  logic [7:0]      waitCnt_q;

  initial begin
    if (WAIT < 1 || WAIT > 255) $error("WAIT must be 1..255");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      waitCnt_q <= 8'h00;
      det.probe <= 1'b0;
      det.found <= 1'b0;
    end else if (det.ce) begin
      det.probe <= 1'b0;
      if (det.clear || !det.enable) begin
        state_q   <= ST_IDLE; // R12
        det.found <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (det.tick) begin
              det.probe <= 1'b1; // R8
              waitCnt_q <= 8'h00;
              state_q   <= ST_SETTLE;
            end
          end
          ST_SETTLE: begin
            if (waitCnt_q == 8'(WAIT - 1)) begin
              if (det.sense) begin
                det.found <= 1'b1; // R10
                state_q   <= ST_FOUND;
              end else begin
                state_q   <= ST_IDLE; // R8
              end
            end else begin
              waitCnt_q <= waitCnt_q + 8'h01;
            end
          end
          ST_FOUND: state_q <= ST_FOUND; // R8
          default:  state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== verif/srtd_far_rx.sv ====
// Far-end receiver model for the three output groups.
// Assumes probe pulses arrive from the block on the same clock.
`timescale 1ns/1ns
module srtd_far_rx
  import srtd_pkg::*;
(
  // Clock.
  input  wire logic                         clk,
  // Probes in, load presence from the bench, sense out.
  input  wire logic [srtd_pkg::NUM_GRP-1:0] rxProbe,
  input  wire logic [srtd_pkg::NUM_GRP-1:0] present,
  output      logic [srtd_pkg::NUM_GRP-1:0] rxSense
);
  // A load answers only once probed, and removing it drops the answer at once.
  initial rxSense = '0;
  always @(posedge clk) rxSense <= present & (rxProbe | rxSense);
endmodule

// ==== verif/srtd_top_assertions.sv ====
// Checker for the strap termination and receiver-detect top.
// Assumes one clock domain; strap changes reach the outputs within four edges.
`timescale 1ns/1ns
module srtd_top_checker
  import srtd_pkg::*;
#(
  parameter int POLL_PERIOD = POLL_CYCLES
) (
  // Clock, reset and enable.
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         ce,
  // Bus activity.
  input wire logic                         wb_cyc_i,
  // Straps, detection and termination.
  input wire logic                         resetStrap,
  input wire logic [2:0]                   pathModeStrap,
  input wire logic [2:0]                   sideChoiceStrapA,
  input wire logic [srtd_pkg::NUM_GRP-1:0] rxSense,
  input wire logic [srtd_pkg::NUM_GRP-1:0] rxProbe,
  input wire logic [srtd_pkg::NUM_GRP-1:0] termOn,
  input wire logic                         lowPower
);
  import srtd_pkg::*;
  logic [19:0] gapCnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Saturates, so a long quiet spell never wraps into a false short gap.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_q <= '1;
    end else if (ce && rxProbe[GRP_D]) begin
      gapCnt_q <= '0;
    end else if (ce && gapCnt_q != '1) begin
      gapCnt_q <= gapCnt_q + 20'h1;
    end
  end
  sequence pollSteady;
    ce && !resetStrap && pathModeStrap == 3'h3 && $stable(sideChoiceStrapA) && !wb_cyc_i;
  endsequence
  lowpwr_hiz_a: assert property ((ce && resetStrap)[*5] |-> termOn == 3'h0 && lowPower)
    else $error("low power with a group terminated");
  mux_term_a: assert property ((ce && !resetStrap && pathModeStrap == 3'h0)[*5]
    |-> termOn == 3'h7 && !lowPower) else $error("mux mode not fully terminated");
  fanout_term_a: assert property ((ce && !resetStrap && pathModeStrap == 3'h7)[*5]
    |-> termOn == 3'h7 && !lowPower) else $error("fanout mode not fully terminated");
  poll_b_side_a: assert property ((ce && !resetStrap && pathModeStrap == 3'h3
    && !sideChoiceStrapA[1])[*5] |-> !termOn[GRP_A]) else $error("A side terminated");
  poll_a_side_a: assert property ((ce && !resetStrap && pathModeStrap == 3'h3
    && sideChoiceStrapA[1])[*5] |-> !termOn[GRP_B]) else $error("B side terminated");
  probe_spacing_a: assert property (ce && rxProbe[GRP_D] |-> gapCnt_q >= POLL_PERIOD - 1)
    else $error("probes closer than one poll interval");
  probe_stop_a: assert property (pollSteady[*6] ##0 termOn[GRP_D] |-> !rxProbe[GRP_D])
    else $error("probe after detection");
  rise_needs_sense_a: assert property ($rose(termOn[GRP_D]) && pathModeStrap == 3'h3
    |-> $past(rxSense[GRP_D], 4)) else $error("terminated without a receiver");
  found_hold_a: assert property (pollSteady[*6] ##0 termOn[GRP_D] |=> termOn[GRP_D])
    else $error("detected termination dropped");
  cover property ($rose(termOn[GRP_D]) && pathModeStrap == 3'h3);
  cover property (rxProbe[GRP_D] && gapCnt_q == 20'(POLL_PERIOD - 1));
  cover property (lowPower && resetStrap);
endmodule
bind srtd_top srtd_top_checker #(.POLL_PERIOD(POLL_PERIOD)) i_srtd_top_checker (
  .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .resetStrap(resetStrap),
  .pathModeStrap(pathModeStrap), .sideChoiceStrapA(sideChoiceStrapA), .rxSense(rxSense),
  .rxProbe(rxProbe), .termOn(termOn), .lowPower(lowPower));

// ==== verif/srtd_top_tb.sv ====
// Self-checking bench for the strap termination and receiver-detect top.
// Assumes the far-end model and the bound checker; straps settle in six edges.
`timescale 1ns/1ns
module srtd_top_tb;
  import srtd_pkg::*;
  localparam int POLL = 20;
  localparam logic [63:0] SWING = 64'hccccbbbaaa999886;
  localparam logic [31:0] DEMC  = 32'he4924910;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ce = 1'b1;
  logic                 cyc = 1'b0;
  logic                 we = 1'b0;
  logic                 resetStrap = 1'b1;
  logic                 ack;
  logic                 lowPower;
  logic [7:0]           adr = 8'h00;
  logic [31:0]          wdat = 32'h0;
  logic [31:0]          rdat;
  logic [31:0]          rd;
  logic [2:0]           pathMode = 3'h0;
  logic [2:0]           sideA = 3'h0;
  logic [2:0]           present = 3'h0;
  logic [2:0]           rxSense;
  logic [2:0]           rxProbe;
  logic [2:0]           termOn;
  logic [1:0][1:0][2:0] deemph = '0;
  logic [1:0][3:0]      swing;
  logic [1:0][4:0]      deemphasis_level;
  int                   miscompares = 0;
  int                   checks_done = 0;
  int                   probes = 0;
  int                   probeBase = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (rxProbe[GRP_D] === 1'b1) probes <= probes + 1;
  srtd_top #(.POLL_PERIOD(POLL)) i_srtd_top (
    .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .resetStrap(resetStrap), .pathModeStrap(pathMode), .sideChoiceStrapA(sideA),
    .sideChoiceStrapB(sideA), .deemphasisStrapPair(deemph), .rxSense(rxSense),
    .rxProbe(rxProbe), .termOn(termOn), .lowPower(lowPower), .outputSwing(swing),
    .deemphasisLevel(deemphasis_level));
  srtd_far_rx i_srtd_far_rx (.clk(clk), .rxProbe(rxProbe), .present(present),
    .rxSense(rxSense));
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    check("wb ack cycles", n, 2);
  endtask
  task automatic strap(input logic r, input logic [2:0] p, s, f);
    @(posedge clk);
    resetStrap <= r;
    pathMode <= p;
    sideA <= s;
    present <= f;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic look(input logic [2:0] t, input logic p);
    check("termOn", termOn, t);
    check("lowPower", lowPower, p);
  endtask
  // Pin levels of one strap pair as thermometer codes, upper pin first.
  function automatic logic [5:0] pins(input logic [3:0] x);
    return {x[3] & x[2], x[3], |x[3:2], x[1] & x[0], x[1], |x[1:0]};
  endfunction
  function automatic logic [4:0] demOf(input logic [1:0] c);
    return c == 2'h0 ? 5'h00 : c == 2'h1 ? 5'h07 : c == 2'h2 ? 5'h0c : 5'h12;
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    strap(1'b1, 3'h0, 3'h0, 3'h7);
    look(3'h0, 1'b1);
    wb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd, 32'h1000);
    wb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    for (int s = 0; s < 8; s += 7) begin
      strap(1'b0, 3'h0, 3'(s), 3'h0);
      look(3'h7, 1'b0);
      strap(1'b0, 3'h7, 3'(s), 3'h0);
      look(3'h7, 1'b0);
    end
    wb(1'b0, ADDR_STATUS, 32'h0);
    check("status", rd, 32'h0075);
    strap(1'b0, 3'h1, 3'h0, 3'h7);
    look(3'h0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      strap(1'b1, 3'h3, 3'h0, 3'h7);
      strap(1'b0, 3'h3, 3'((1 << s) - 1), 3'h7);
      look(3'h0, 1'b0);
      repeat (2 * POLL) @(posedge clk);
      #1 look(s < 2 ? 3'h6 : 3'h5, 1'b0);
    end
    strap(1'b0, 3'h3, 3'h0, 3'h7);
    look(3'h0, 1'b0);
    repeat (2 * POLL) @(posedge clk);
    wb(1'b1, ADDR_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    #1 look(3'h0, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h1);
    probeBase = probes;
    repeat (3 * POLL) @(posedge clk);
    #1 check("paused probes", probes - probeBase, 0);
    strap(1'b0, 3'h3, 3'h0, 3'h0);
    wb(1'b1, ADDR_CTRL, 32'h0);
    @(posedge clk);
    probeBase = probes;
    repeat (3 * POLL) @(posedge clk);
    #1 check("probe count", probes - probeBase, 3);
    look(3'h0, 1'b0);
    strap(1'b0, 3'h3, 3'h0, 3'h7);
    repeat (2 * POLL) @(posedge clk);
    #1 look(3'h6, 1'b0);
    probeBase = probes;
    repeat (3 * POLL) @(posedge clk);
    #1 check("late probes", probes - probeBase, 0);
    // With the enable low the power-down strap must not reach the outputs.
    @(posedge clk);
    ce <= 1'b0;
    strap(1'b1, 3'h3, 3'h0, 3'h7);
    look(3'h6, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    #1 look(3'h0, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      deemph <= {pins(4'(15 - i)), pins(4'(i))};
      repeat (6) @(posedge clk);
      #1 check("swing0", swing[0], SWING[4 * i +: 4]);
      check("swing1", swing[1], SWING[4 * (15 - i) +: 4]);
      check("dem0", deemphasis_level[0], demOf(DEMC[2 * i +: 2]));
      check("dem1", deemphasis_level[1], demOf(DEMC[2 * (15 - i) +: 2]));
    end
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
